// file: dac_front_pkg.sv
// constants shared by the dac input register and segment decoder
package dac_front_pkg;
    localparam int WORD_W = 12;
    localparam int MSB_W = 4;
    localparam int THERMO_W = 15;
    localparam int SW_W = 23;
    // switch vector layout
    localparam int THERMO_LSB = 8;
    localparam int TOP_BIN_LSB = 6;
    localparam int TOP_BIN_W = 2;
    localparam int MID_BIN_LSB = 3;
    localparam int MID_BIN_W = 3;
    localparam int LOW_BIN_LSB = 0;
    localparam int LOW_BIN_W = 3;
    // pin vector layout: {select, clock true, clock complement, word}
    localparam int PIN_W = WORD_W + 3;
    localparam int PIN_SEL = WORD_W + 2;
    localparam int PIN_CLK_T = WORD_W + 1;
    localparam int PIN_CLK_C = WORD_W;
    // reset values
    localparam logic [PIN_W-1:0] PIN_RST = 15'h0000;
    localparam logic [SW_W-1:0] SW_RST = 23'h000000;
endpackage

// file: dac_input_register_segment_decoder.sv
// master/slave input register and segment decoder of a 12-bit segmented dac
// What this block does
// - clocked mode, clock low: master follows input word, slave holds its contents
// - rising clock edge freezes master and copies it into slave in same edge
// - select high: both stages pass input straight to switch controls, clock ignored
// - four top bits decode to 15 thermometer enables, count equals their value
// - bits 11..6 drive 15 thermometer switches plus bits 7 and 6 binary
// - bits 5..3 each drive one binary switch on the ladder middle node
// - bits 2..0 each drive one binary switch on the ladder input node
// - all 23 switch controls retimed by their own stage, changing together
// - straight binary coding: all zeros gives all switches off, all ones all on
module dac_input_register_segment_decoder (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] sample_word_bits,
    input wire logic sample_clk_true,
    input wire logic sample_clk_comp,
    input wire logic transparent_sel,
    output logic [14:0] thermo_sw,
    output logic [1:0] top_bin_sw,
    output logic [2:0] mid_bin_sw,
    output logic [2:0] low_bin_sw
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // word to 23 switch controls; msb decode happens before the master stage
    // so its delay never shows at the switches
    function automatic logic [dac_front_pkg::SW_W-1:0] encode_switches(
        input logic [dac_front_pkg::WORD_W-1:0] word
    );
        logic [dac_front_pkg::SW_W-1:0] sw;
        logic [dac_front_pkg::MSB_W-1:0] msbs;
        sw = '0;
        msbs = word[dac_front_pkg::WORD_W-1 -: dac_front_pkg::MSB_W];
        for (int i = 0; i < dac_front_pkg::THERMO_W; i++) begin
            sw[dac_front_pkg::THERMO_LSB + i] = (i < int'(msbs));
        end
        // straight binary, no inversion
        sw[dac_front_pkg::TOP_BIN_LSB +: dac_front_pkg::TOP_BIN_W] =
            word[dac_front_pkg::TOP_BIN_LSB +: dac_front_pkg::TOP_BIN_W];
        sw[dac_front_pkg::MID_BIN_LSB +: dac_front_pkg::MID_BIN_W] =
            word[dac_front_pkg::MID_BIN_LSB +: dac_front_pkg::MID_BIN_W];
        sw[dac_front_pkg::LOW_BIN_LSB +: dac_front_pkg::LOW_BIN_W] =
            word[dac_front_pkg::LOW_BIN_LSB +: dac_front_pkg::LOW_BIN_W];
        return sw;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [dac_front_pkg::PIN_W-1:0] pins;
    logic [dac_front_pkg::PIN_W-1:0] s1_r, s2_r, s3_r, filt_r;
    logic [dac_front_pkg::PIN_W-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;
    logic lvl_r, lvl_nxt;

    // stage one may be metastable, so only stage two ever reads it
    assign pins = {transparent_sel, sample_clk_true, sample_clk_comp, sample_word_bits};

    logic [dac_front_pkg::WORD_W-1:0] word_f;
    logic sel_f, lvl_now, rise;

    assign word_f = filt_r[dac_front_pkg::WORD_W-1:0];
    assign sel_f = filt_r[dac_front_pkg::PIN_SEL];
    // differential clock: high while true side is above complement
    assign lvl_now = filt_r[dac_front_pkg::PIN_CLK_T] & ~filt_r[dac_front_pkg::PIN_CLK_C];
    assign rise = lvl_now & ~lvl_r;

    always_comb begin
        s1_nxt = pins;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        // a bit moves only once stages two and three agree
        filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
        lvl_nxt = lvl_now;
        if (rst) begin
            s1_nxt = dac_front_pkg::PIN_RST;
            s2_nxt = dac_front_pkg::PIN_RST;
            s3_nxt = dac_front_pkg::PIN_RST;
            filt_nxt = dac_front_pkg::PIN_RST;
            lvl_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        s1_r <= s1_nxt;
        s2_r <= s2_nxt;
        s3_r <= s3_nxt;
        filt_r <= filt_nxt;
        lvl_r <= lvl_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // master/slave register, one stage per switch line

    logic [dac_front_pkg::SW_W-1:0] master_r, master_nxt, slave_r, slave_nxt;
    logic [dac_front_pkg::SW_W-1:0] enc_now;

    assign enc_now = encode_switches(word_f);

    always_comb begin
        master_nxt = master_r;
        slave_nxt = slave_r;
        // a word settling in the cycle of the rise is dropped, never half taken
        if (sel_f || !lvl_now) begin
            master_nxt = enc_now;
        end
        // transparent mode still pays the synchroniser delay; outputs stay flops
        if (sel_f) begin
            slave_nxt = enc_now;
        end else if (rise) begin
            slave_nxt = master_r;
        end
        // only a model-level clear; the register itself has none
        if (rst) begin
            master_nxt = dac_front_pkg::SW_RST;
            slave_nxt = dac_front_pkg::SW_RST;
        end
    end

    always_ff @(posedge clk) begin
        master_r <= master_nxt;
        slave_r <= slave_nxt;
    end

    assign thermo_sw = slave_r[dac_front_pkg::THERMO_LSB +: dac_front_pkg::THERMO_W];
    assign top_bin_sw = slave_r[dac_front_pkg::TOP_BIN_LSB +: dac_front_pkg::TOP_BIN_W];
    assign mid_bin_sw = slave_r[dac_front_pkg::MID_BIN_LSB +: dac_front_pkg::MID_BIN_W];
    assign low_bin_sw = slave_r[dac_front_pkg::LOW_BIN_LSB +: dac_front_pkg::LOW_BIN_W];

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // clocked checks follow the filtered clock, a few edges behind the pins

    a_master_follow_low: assert property (
        (!sel_f && !lvl_now) |=> master_r == $past(enc_now))
        else $error("master did not follow input while clock low");

    a_slave_hold_low: assert property (
        (!sel_f && !rise) |=> $stable(slave_r))
        else $error("slave changed without an edge in clocked mode");

    a_edge_copy: assert property (
        (!sel_f && rise) |=> slave_r == $past(master_r))
        else $error("slave did not take master on rising edge");

    a_master_frozen_high: assert property (
        (!sel_f && lvl_now) |=> $stable(master_r))
        else $error("master moved while clock high");

    a_transparent_pass: assert property (
        sel_f |=> (slave_r == $past(enc_now)) && (master_r == $past(enc_now)))
        else $error("transparent mode did not pass the word");

    a_thermo_form: assert property (
        ##1 ((thermo_sw & (thermo_sw + 15'h0001)) == 15'h0000))
        else $error("thermometer lines not contiguous from bit zero");

    a_thermo_count: assert property (
        sel_f |=> $countones(thermo_sw) == int'($past(word_f[11:8])))
        else $error("thermometer count differs from top four bits");

    a_top_binary: assert property (
        (!sel_f && rise) |=> top_bin_sw == $past(word_f[7:6], 2))
        else $error("top binary switches wrong after edge");

    a_mid_binary: assert property (
        (!sel_f && rise) |=> mid_bin_sw == $past(word_f[5:3], 2))
        else $error("middle group switches wrong after edge");

    a_low_binary: assert property (
        (!sel_f && rise) |=> low_bin_sw == $past(word_f[2:0], 2))
        else $error("low group switches wrong after edge");

    a_switches_together: assert property (
        (!rise && !sel_f) |=> $stable({thermo_sw, top_bin_sw, mid_bin_sw, low_bin_sw}))
        else $error("switch lines changed outside an update");

    a_code_extremes: assert property (
        (sel_f && word_f == 12'hfff) |=> slave_r == 23'h7fffff)
        else $error("all ones word did not turn every switch on");

    a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> slave_r == dac_front_pkg::SW_RST)
        else $error("switches not cleared by reset");

    a_code_zero: assert property (
        (!sel_f && rise && $past(word_f) == 12'h000) |=> slave_r == 23'h000000)
        else $error("all zeros word left a switch on after edge");

    a_code_full: assert property (
        (!sel_f && rise && $past(word_f) == 12'hfff) |=> slave_r == 23'h7fffff)
        else $error("all ones word missed a switch after edge");

    a_thermo_count_clk: assert property (
        (!sel_f && rise) |=> $countones(thermo_sw) == int'($past(word_f[11:8], 2)))
        else $error("thermometer count wrong after clocked update");

    a_late_word_ignored: assert property (
        (!sel_f && lvl_now && $changed(word_f)) |=> $stable(master_r))
        else $error("master took a word while clock high");

    a_thermo_master: assert property (
        (master_r[22:8] & (master_r[22:8] + 15'h0001)) == 15'h0000)
        else $error("master thermometer lines not contiguous");

    a_sync_agree: assert property (
        (s2_r == s3_r) |=> filt_r == $past(s3_r))
        else $error("pin filter ignored two agreeing stages");

    ////////////////////////////////////////////////////////////////////////////
    // covers

    c_clocked_update: cover property (!sel_f && rise ##1 thermo_sw == 15'h7fff);
    c_transparent_use: cover property (sel_f ##1 sel_f && !$stable(slave_r));
    c_full_scale_step: cover property (slave_r == 23'h000000 ##[1:20] slave_r == 23'h7fffff);
    c_word_ignored: cover property (!sel_f && lvl_now && $changed(word_f));
    c_select_clock_fall: cover property (sel_f && lvl_now ##1 sel_f && !lvl_now);

endmodule // dac_input_register_segment_decoder

// file: sample_source.sv
// sample source model driving the front end pins from the bench side
module sample_source (
    input wire logic clk,
    output logic [11:0] word,
    output logic clk_true,
    output logic clk_comp,
    output logic sel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word = 12'h000;
        clk_true = 1'b0;
        clk_comp = 1'b1;
        sel = 1'b0;
    end
    // pins move on the falling edge, then stand 10 cycles for the synchronisers
    task automatic drive(input logic [11:0] w, input logic c, input logic s);
        @(negedge clk);
        word = w;
        clk_true = c;
        clk_comp = ~c;
        sel = s;
        repeat (10) @(negedge clk);
    endtask
endmodule // sample_source

// file: dac_input_register_segment_decoder_test.sv
// self-checking bench for the dac input register and segment decoder
module dac_input_register_segment_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] word;
    logic ct;
    logic cc;
    logic sel;
    logic [14:0] thermo_sw;
    logic [1:0] top_bin_sw;
    logic [2:0] mid_bin_sw;
    logic [2:0] low_bin_sw;
    logic [22:0] held;
    int n_mismatch = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk = ~clk;
    end
    sample_source sample_source_i (.clk(clk), .word(word), .clk_true(ct), .clk_comp(cc),
        .sel(sel));
    dac_input_register_segment_decoder dac_input_register_segment_decoder_i (
        .clk(clk), .rst(rst), .sample_word_bits(word), .sample_clk_true(ct),
        .sample_clk_comp(cc), .transparent_sel(sel), .thermo_sw(thermo_sw),
        .top_bin_sw(top_bin_sw), .mid_bin_sw(mid_bin_sw), .low_bin_sw(low_bin_sw));
    ////////////////////////////////////////////////////////////////////////
    // expected switch vector: thermometer from top nibble, low byte passes straight
    function automatic logic [22:0] enc(input logic [11:0] w);
        logic [14:0] t;
        t = 15'h7fff >> (15 - int'(w[11:8]));
        return {t, w[7:0]};
    endfunction
    task automatic check_sw(input logic [22:0] exp);
        logic [22:0] got;
        got = {thermo_sw, top_bin_sw, mid_bin_sw, low_bin_sw};
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check_sw(23'h000000);
    endtask
    // every top nibble value; word changes while clock high must be ignored
    task automatic t_clocked();
        logic [11:0] w;
        for (int n = 0; n < 16; n++) begin
            w = {n[3:0], 8'h5a ^ n[7:0]};
            sample_source_i.drive(w, 1'b0, 1'b0);
            check_sw(held);
            sample_source_i.drive(w, 1'b1, 1'b0);
            check_sw(enc(w));
            held = enc(w);
            sample_source_i.drive(~w, 1'b1, 1'b0);
            check_sw(held);
        end
    endtask
    task automatic t_coding();
        sample_source_i.drive(12'h000, 1'b0, 1'b0);
        sample_source_i.drive(12'h000, 1'b1, 1'b0);
        check_sw(23'h000000);
        sample_source_i.drive(12'hfff, 1'b0, 1'b0);
        sample_source_i.drive(12'hfff, 1'b1, 1'b0);
        check_sw(23'h7fffff);
        held = 23'h7fffff;
    endtask
    // transparent mode follows the word with clock high and low alike
    task automatic t_transparent();
        sample_source_i.drive(12'h8c3, 1'b1, 1'b1);
        check_sw(enc(12'h8c3));
        sample_source_i.drive(12'h13c, 1'b1, 1'b1);
        check_sw(enc(12'h13c));
        sample_source_i.drive(12'hf81, 1'b0, 1'b1);
        check_sw(enc(12'hf81));
        sample_source_i.drive(12'hfff, 1'b0, 1'b1);
        check_sw(23'h7fffff);
    endtask
    // mid-run clear from full scale, then transparent mode refills the switches
    task automatic t_reset_again();
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check_sw(23'h000000);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        check_sw(23'h7fffff);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        held = 23'h000000;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_clocked();
        t_coding();
        t_transparent();
        t_reset_again();
        final_report();
    end
    // whole run is near 640 cycles; cut off well beyond that
    initial begin
        #200us;
        n_mismatch++;
        final_report();
    end
endmodule // dac_input_register_segment_decoder_test
